// [include/eirq_map.vh]
// Purpose: Constants for the external request flag and priority block
// Assumes: Register index = printed offset, byte address = index * 4
// Notes:   Only the low byte of each word is implemented
//
// Function
// - Level mode: flag is set every cycle the request input is low.
// - Edge mode: flag is set on a high-to-low request input change.
// - Flag clears after a read showing 1, then a written 0, or by exception handling.
// - Level mode: exception handling clears flag while the input is high.
// - Edge mode: exception handling always clears the flag.
// - Flag bits accept only 0; writing 1 does nothing; bits 7:6 absent.
// - Priority bit 0 means low level, 1 means high level.
// - Register A bits map to inputs 0,1,2-3,4-5, watchdog, timers 0-2.
// - Register B bits map to timers 3-4, DMA, serial 0-1, converter.
// - Both priority registers reset to zero, all bits read and write.
// - Sense select 0 is level, 1 is falling edge, all reset to 0.
// - Per-input enable gates the request to the CPU, resets to 0.
`ifndef EIRQ_MAP_VH
`define EIRQ_MAP_VH

// ====================================================================
// Sizes
`define EIRQ_NUM_IN      6
`define EIRQ_ADDR_W      10
`define EIRQ_DATA_W      32
`define EIRQ_ID_W        3

// ====================================================================
// Register indices (byte address is index * 4)
`define EIRQ_IDX_SENSE   8'hf4
`define EIRQ_IDX_ENABLE  8'hf5
`define EIRQ_IDX_FLAGS   8'hf6
`define EIRQ_IDX_PRIO_A  8'hf8
`define EIRQ_IDX_PRIO_B  8'hf9
`define EIRQ_IDX_ISTAT   8'hfa
`define EIRQ_IDX_ICLR    8'hfb
`define EIRQ_IDX_IEN     8'hfc

// ====================================================================
// Reset values
`define EIRQ_RST_SENSE   6'h00
`define EIRQ_RST_ENABLE  6'h00
`define EIRQ_RST_FLAGS   6'h00
`define EIRQ_RST_PRIO    8'h00
`define EIRQ_RST_INT     6'h00
`define EIRQ_RST_PIN     3'h7

// ====================================================================
// Priority register A fields
`define EIRQ_PA_IN0      7
`define EIRQ_PA_IN1      6
`define EIRQ_PA_IN23     5
`define EIRQ_PA_IN45     4
`define EIRQ_PA_WDT      3
`define EIRQ_PA_TMR0     2
`define EIRQ_PA_TMR1     1
`define EIRQ_PA_TMR2     0
// Priority register B fields, bits 4 and 0 reserved but stored
`define EIRQ_PB_TMR3     7
`define EIRQ_PB_TMR4     6
`define EIRQ_PB_DMA      5
`define EIRQ_PB_SER0     3
`define EIRQ_PB_SER1     2
`define EIRQ_PB_ADC      1

`endif

// [src/eirq_sync.v]
// Purpose: Three-stage synchroniser with settled level and fall pulse
// Assumes: Inputs idle high, asynchronous to i_clock
// Notes:   A change counts once stages one and two agree
`timescale 1ns/1ns
`include "eirq_map.vh"

module eirq_sync (
  input  wire                     i_clock,
  input  wire                     i_sys_rst,
  input  wire [`EIRQ_NUM_IN-1:0]  i_pin,
  output wire [`EIRQ_NUM_IN-1:0]  o_level,
  output wire [`EIRQ_NUM_IN-1:0]  o_fall
);

  genvar g;
  generate
    for (g = 0; g < `EIRQ_NUM_IN; g = g + 1) begin : g_bit
      reg [2:0] stage_q;
      reg       level_q;
      reg       fall_q;
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          stage_q <= `EIRQ_RST_PIN;
          level_q <= 1'b1;
          fall_q  <= 1'b0;
        end else begin
          stage_q <= {stage_q[1:0], i_pin[g]};
          // Stage 0 feeds only stage 1
          if (stage_q[1] == stage_q[2]) begin
            level_q <= stage_q[2];
          end
          fall_q <= (stage_q[1] == stage_q[2]) & ~stage_q[2] & level_q;
        end
      end
      assign o_level[g] = level_q;
      assign o_fall[g]  = fall_q;
    end
  endgenerate

endmodule // eirq_sync

// [src/eirq_prio.v]
// Purpose: Two-level fixed-order arbiter for the external requests
// Assumes: Pending vector already gated by enables
// Notes:   Lower input number wins within a level
`timescale 1ns/1ns
`include "eirq_map.vh"

module eirq_prio (
  input  wire                     i_clock,
  input  wire                     i_sys_rst,
  input  wire [`EIRQ_NUM_IN-1:0]  i_pending,
  input  wire [7:0]               i_prio_a,
  output reg                      o_req,
  output reg  [`EIRQ_ID_W-1:0]    o_id,
  output reg                      o_high
);

  reg [`EIRQ_NUM_IN-1:0] level_hi;
  reg [`EIRQ_NUM_IN-1:0] pend_hi;
  reg [`EIRQ_NUM_IN-1:0] pick;
  reg [`EIRQ_ID_W-1:0]   id_d;

  // Lowest set bit as an index
  function [`EIRQ_ID_W-1:0] first_set;
    input [`EIRQ_NUM_IN-1:0] v;
    integer j;
    begin
      first_set = {`EIRQ_ID_W{1'b0}};
      for (j = `EIRQ_NUM_IN - 1; j >= 0; j = j - 1) begin
        if (v[j]) begin
          first_set = j[`EIRQ_ID_W-1:0];
        end
      end
    end
  endfunction

  always @* begin
    level_hi = {i_prio_a[`EIRQ_PA_IN45], i_prio_a[`EIRQ_PA_IN45],
                i_prio_a[`EIRQ_PA_IN23], i_prio_a[`EIRQ_PA_IN23],
                i_prio_a[`EIRQ_PA_IN1],  i_prio_a[`EIRQ_PA_IN0]};
    pend_hi  = i_pending & level_hi;
    pick     = (|pend_hi) ? pend_hi : i_pending;
    id_d     = first_set(pick);
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_req  <= 1'b0;
      o_id   <= {`EIRQ_ID_W{1'b0}};
      o_high <= 1'b0;
    end else begin
      o_req  <= |i_pending;
      o_id   <= id_d;
      o_high <= |pend_hi;
    end
  end

endmodule // eirq_prio

// [src/eirq_top.v]
// Purpose: External request flags, sense/enable and priority registers
// Assumes: Avalon-MM slave, byte address, one wait cycle per access
// Notes:   Flags clear by read-then-write-0 or by exception handling
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
`include "eirq_map.vh"

module eirq_top (
  input  wire                     i_clock,
  input  wire                     i_sys_rst,
  input  wire [`EIRQ_ADDR_W-1:0]  i_avs_address,
  input  wire                     i_avs_read,
  input  wire                     i_avs_write,
  input  wire [`EIRQ_DATA_W-1:0]  i_avs_writedata,
  input  wire [3:0]               i_avs_byteenable,
  output reg  [`EIRQ_DATA_W-1:0]  o_avs_readdata,
  output wire                     o_avs_waitrequest,
  input  wire [`EIRQ_NUM_IN-1:0]  i_ext_request_n,
  input  wire                     i_exc_take,
  input  wire [`EIRQ_ID_W-1:0]    i_exc_id,
  output wire                     o_cpu_req,
  output wire [`EIRQ_ID_W-1:0]    o_cpu_id,
  output wire                     o_cpu_high,
  output wire [7:0]               o_priority_group_a_bits,
  output wire [7:0]               o_priority_group_b_bits,
  output wire [`EIRQ_NUM_IN-1:0]  o_ext_request_flag,
  output wire                     o_irq
);

  // ==================================================================
  // Bus handshake
  reg                      ack_q;
  wire                     req;
  wire                     acc;
  wire [7:0]               idx;
  wire                     lane0;

  assign req               = i_avs_read | i_avs_write;
  // One wait cycle, so readdata is from a flop when accepted
  assign o_avs_waitrequest = req & ~ack_q;
  assign acc               = req & ack_q;
  assign idx               = i_avs_address[`EIRQ_ADDR_W-1:2];
  assign lane0             = i_avs_byteenable[0];

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function hit;
    input [7:0] a;
    input [7:0] want;
    begin
      hit = (a == want);
    end
  endfunction

  wire wr_en;
  wire rd_acc;
  assign wr_en  = acc & i_avs_write & lane0 & (i_avs_address[1:0] == 2'b00);
  assign rd_acc = acc & i_avs_read & (i_avs_address[1:0] == 2'b00);

  // ==================================================================
  // Pin synchroniser
  wire [`EIRQ_NUM_IN-1:0] pin_level;
  wire [`EIRQ_NUM_IN-1:0] pin_fall;

  eirq_sync u_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_request_n),
    .o_level   (pin_level),
    .o_fall    (pin_fall)
  );

  // ==================================================================
  // Control registers
  reg [`EIRQ_NUM_IN-1:0] ext_sense_select_q;
  reg [`EIRQ_NUM_IN-1:0] ext_request_enable_q;
  reg [7:0]              prio_level_a_q;
  reg [7:0]              prio_level_b_q;
  reg [`EIRQ_NUM_IN-1:0] irq_en_q;

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ext_sense_select_q   <= `EIRQ_RST_SENSE;
      ext_request_enable_q <= `EIRQ_RST_ENABLE;
      prio_level_a_q       <= `EIRQ_RST_PRIO;
      prio_level_b_q       <= `EIRQ_RST_PRIO;
      irq_en_q             <= `EIRQ_RST_INT;
    end else if (wr_en) begin
      if (hit(idx, `EIRQ_IDX_SENSE)) begin
        ext_sense_select_q <= i_avs_writedata[`EIRQ_NUM_IN-1:0];
      end
      if (hit(idx, `EIRQ_IDX_ENABLE)) begin
        ext_request_enable_q <= i_avs_writedata[`EIRQ_NUM_IN-1:0];
      end
      if (hit(idx, `EIRQ_IDX_PRIO_A)) begin
        prio_level_a_q <= i_avs_writedata[7:0];
      end
      if (hit(idx, `EIRQ_IDX_PRIO_B)) begin
        prio_level_b_q <= i_avs_writedata[7:0];
      end
      if (hit(idx, `EIRQ_IDX_IEN)) begin
        irq_en_q <= i_avs_writedata[`EIRQ_NUM_IN-1:0];
      end
    end
  end

  // ==================================================================
  // Request flags
  reg  [`EIRQ_NUM_IN-1:0] flag_q;
  reg  [`EIRQ_NUM_IN-1:0] flag_d;
  reg  [`EIRQ_NUM_IN-1:0] armed_q;
  reg  [`EIRQ_NUM_IN-1:0] armed_d;
  reg  [`EIRQ_NUM_IN-1:0] set_v;
  reg  [`EIRQ_NUM_IN-1:0] clr_v;
  reg  [`EIRQ_NUM_IN-1:0] exc_v;
  wire                    flag_wr;
  wire                    flag_rd;
  integer                 n;

  assign flag_wr = wr_en & hit(idx, `EIRQ_IDX_FLAGS);
  assign flag_rd = rd_acc & hit(idx, `EIRQ_IDX_FLAGS);

  always @* begin
    set_v   = {`EIRQ_NUM_IN{1'b0}};
    clr_v   = {`EIRQ_NUM_IN{1'b0}};
    exc_v   = {`EIRQ_NUM_IN{1'b0}};
    armed_d = armed_q;
    for (n = 0; n < `EIRQ_NUM_IN; n = n + 1) begin
      if (ext_sense_select_q[n]) begin
        set_v[n] = pin_fall[n];
      end else begin
        set_v[n] = ~pin_level[n];
      end
      exc_v[n] = i_exc_take & (i_exc_id == n[`EIRQ_ID_W-1:0]);
      if (ext_sense_select_q[n]) begin
        clr_v[n] = exc_v[n];
      end else begin
        clr_v[n] = exc_v[n] & pin_level[n];
      end
      // Written 1 is ignored, 0 clears only when armed
      if (flag_wr & ~i_avs_writedata[n] & armed_q[n]) begin
        clr_v[n] = 1'b1;
      end
      // Arm from the value the read actually returned
      if (flag_rd & o_avs_readdata[n]) begin
        armed_d[n] = 1'b1;
      end
      if (clr_v[n] | ~flag_q[n]) begin
        armed_d[n] = 1'b0;
      end
    end
    // New event beats a clear in the same cycle
    flag_d = (flag_q & ~clr_v) | set_v;
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      flag_q  <= `EIRQ_RST_FLAGS;
      armed_q <= `EIRQ_RST_FLAGS;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  // ==================================================================
  // Sticky event status and interrupt line
  reg  [`EIRQ_NUM_IN-1:0] istat_q;
  wire [`EIRQ_NUM_IN-1:0] istat_clr;
  wire [`EIRQ_NUM_IN-1:0] flag_rise;

  assign flag_rise = flag_d & ~flag_q;
  assign istat_clr = (wr_en & hit(idx, `EIRQ_IDX_ICLR)) ?
                     i_avs_writedata[`EIRQ_NUM_IN-1:0] : {`EIRQ_NUM_IN{1'b0}};

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      istat_q <= `EIRQ_RST_INT;
    end else begin
      istat_q <= (istat_q & ~istat_clr) | flag_rise;
    end
  end

  assign o_irq = |(istat_q & irq_en_q);

  // ==================================================================
  // Arbitration towards the CPU
  eirq_prio u_prio (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_pending (flag_q & ext_request_enable_q),
    .i_prio_a  (prio_level_a_q),
    .o_req     (o_cpu_req),
    .o_id      (o_cpu_id),
    .o_high    (o_cpu_high)
  );

  assign o_priority_group_a_bits = prio_level_a_q;
  assign o_priority_group_b_bits = prio_level_b_q;
  assign o_ext_request_flag      = flag_q;

  // ==================================================================
  // Read data, captured in the wait cycle
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (i_avs_address[1:0] == 2'b00) begin
      case (idx)
        `EIRQ_IDX_SENSE:  rd_byte = {2'b00, ext_sense_select_q};
        `EIRQ_IDX_ENABLE: rd_byte = {2'b00, ext_request_enable_q};
        `EIRQ_IDX_FLAGS:  rd_byte = {2'b00, flag_q};
        `EIRQ_IDX_PRIO_A: rd_byte = prio_level_a_q;
        `EIRQ_IDX_PRIO_B: rd_byte = prio_level_b_q;
        `EIRQ_IDX_ISTAT:  rd_byte = {2'b00, istat_q};
        `EIRQ_IDX_IEN:    rd_byte = {2'b00, irq_en_q};
        default:          rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_avs_readdata <= {`EIRQ_DATA_W{1'b0}};
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= {24'h000000, rd_byte};
    end
  end

endmodule // eirq_top

// [verification/eirq_cpu_model.sv]
// Purpose: CPU side that carries out exception handling on request
// Assumes: Takes the presented winner, one pulse per handling
// Notes:   Slow mode spaces handlings further apart
`timescale 1ns/1ns
`include "eirq_map.vh"

module eirq_cpu_model (
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_run,
  input  wire logic                  i_slow,
  input  wire logic                  i_req,
  input  wire logic [`EIRQ_ID_W-1:0] i_id,
  output logic                       o_take,
  output logic [`EIRQ_ID_W-1:0]      o_id
);
  logic [3:0] gap_q;

  // ==========
  // Handling
  always @(posedge i_clock) begin
    o_take <= 1'b0;
    if (i_sys_rst || !i_run) begin
      gap_q <= 4'h0;
      o_id  <= 3'h0;
    end else if (gap_q != 4'h0) begin
      // Gap lets the cleared flag reach the request line
      gap_q <= gap_q - 4'h1;
    end else if (i_req) begin
      o_take <= 1'b1;
      o_id   <= i_id;
      gap_q  <= i_slow ? 4'hf : 4'h4;
    end
  end
endmodule // eirq_cpu_model

// [verification/eirq_assertions.sv]
// Purpose: Port checks for the request flag and priority block
// Assumes: Byte address is register index times four
// Notes:   Sense and enable are not visible here
`timescale 1ns/1ns
`include "eirq_map.vh"

module eirq_checker (
  input wire logic                     i_clock,
  input wire logic                     i_sys_rst,
  input wire logic [`EIRQ_ADDR_W-1:0]  i_avs_address,
  input wire logic                     i_avs_read,
  input wire logic                     i_avs_write,
  input wire logic [`EIRQ_DATA_W-1:0]  i_avs_writedata,
  input wire logic [3:0]               i_avs_byteenable,
  input wire logic [`EIRQ_DATA_W-1:0]  o_avs_readdata,
  input wire logic                     o_avs_waitrequest,
  input wire logic [`EIRQ_NUM_IN-1:0]  i_ext_request_n,
  input wire logic                     i_exc_take,
  input wire logic                     o_cpu_req,
  input wire logic [`EIRQ_ID_W-1:0]    o_cpu_id,
  input wire logic                     o_cpu_high,
  input wire logic [7:0]               o_priority_group_a_bits,
  input wire logic [`EIRQ_NUM_IN-1:0]  o_ext_request_flag
);
  logic [47:0] low_q;
  logic [5:0]  flag_q;
  logic [7:0]  pa_q;
  logic [7:0]  wd_q;
  logic        exc_q;
  logic        wrf_q;
  wire         rd_ok = i_avs_read & ~o_avs_waitrequest;
  wire         wr_ok = i_avs_write & ~o_avs_waitrequest;
  // Pin low anywhere in the last eight cycles covers synchroniser lag
  wire  [5:0]  low_any = low_q[5:0] | low_q[11:6] | low_q[17:12] | low_q[23:18]
                       | low_q[29:24] | low_q[35:30] | low_q[41:36] | low_q[47:42];
  wire  [2:0]  win_bit = (o_cpu_id < 3'h2) ? 3'h7 - o_cpu_id
                       : ((o_cpu_id < 3'h4) ? 3'h5 : 3'h4);

  always @(posedge i_clock) begin
    low_q  <= {low_q[41:0], ~i_ext_request_n};
    flag_q <= o_ext_request_flag;
    pa_q   <= o_priority_group_a_bits;
    wd_q   <= i_avs_writedata[7:0];
    exc_q  <= i_exc_take;
    wrf_q  <= wr_ok && (i_avs_address == 10'h3d8);
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // ==========
  // Assertions
  a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus wait not one cycle");
  a_flag_read: assert property (rd_ok && i_avs_address == 10'h3d8
    |-> o_avs_readdata == {26'h0, flag_q}) else $error("flag read wrong");
  a_prio_write: assert property (wr_ok && i_avs_address == 10'h3e0
    && i_avs_byteenable[0] |=> o_priority_group_a_bits == wd_q) else $error("prio write lost");
  a_prio_keep: assert property (wr_ok && !i_avs_byteenable[0]
    |=> $stable(o_priority_group_a_bits)) else $error("prio changed without lane");
  a_prio_read: assert property (rd_ok && i_avs_address == 10'h3e0
    |-> o_avs_readdata == {24'h0, pa_q}) else $error("prio read wrong");
  a_flag_rise: assert property (
    (o_ext_request_flag & ~flag_q & ~low_any) == 6'h00) else $error("flag set without pin");
  a_flag_clear: assert property ((flag_q & ~o_ext_request_flag) != 6'h00
    |-> exc_q || wrf_q) else $error("flag cleared without cause");
  a_req_flag: assert property (o_cpu_req |-> flag_q != 6'h00)
    else $error("request without flag");
  a_win_flag: assert property (o_cpu_req |-> o_cpu_id <= 3'h5 && flag_q[o_cpu_id])
    else $error("winner not pending");
  a_win_level: assert property (o_cpu_req |-> o_cpu_high == pa_q[win_bit])
    else $error("winner level wrong");

  c_high_win: cover property (o_cpu_req && o_cpu_high);
  c_exc_clear: cover property (exc_q && flag_q != 6'h00);
  c_sw_clear: cover property (wrf_q && flag_q != 6'h00);
endmodule // eirq_checker

bind eirq_top eirq_checker u_eirq_checker (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_ext_request_n(i_ext_request_n),
  .i_exc_take(i_exc_take), .o_cpu_req(o_cpu_req), .o_cpu_id(o_cpu_id),
  .o_cpu_high(o_cpu_high), .o_priority_group_a_bits(o_priority_group_a_bits),
  .o_ext_request_flag(o_ext_request_flag));

// [verification/external_irq_flag_priority_test.sv]
// Purpose: Self-checking bench for the request flag block
// Assumes: One wait cycle per bus access, CPU model on the far side
// Notes:   Reads queue their expectation, a monitor compares
`timescale 1ns/1ns
`include "eirq_map.vh"

module external_irq_flag_priority_test;
  logic        i_clock, i_sys_rst, rd, wr, run, slow, take, req, high, irq, wt;
  logic [9:0]  addr;
  logic [31:0] wd, rdata, seed;
  logic [3:0]  be;
  logic [5:0]  pin_n, flags;
  logic [7:0]  pa, pb;
  logic [2:0]  tid, cid;
  logic [31:0] exq[$];
  int          err_count, check_count, cycles;

  eirq_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_ext_request_n(pin_n),
    .i_exc_take(take), .i_exc_id(tid), .o_cpu_req(req), .o_cpu_id(cid), .o_cpu_high(high),
    .o_priority_group_a_bits(pa), .o_priority_group_b_bits(pb), .o_ext_request_flag(flags),
    .o_irq(irq));
  eirq_cpu_model u_cpu (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_run(run), .i_slow(slow),
    .i_req(req), .i_id(cid), .o_take(take), .o_id(tid));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // For a read, d is the expected data and is queued for the monitor
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge i_clock);
    addr <= {idx, 2'b00};
    rd   <= !w;
    wr   <= w;
    wd   <= d;
    if (!w) exq.push_back(d);
    do @(posedge i_clock); while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // ==========
  // Monitor and timeout
  always @(posedge i_clock) begin
    if (rd && wt === 1'b0 && exq.size() > 0) cmp(rdata, exq.pop_front());
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      complete_run;
    end
  end

  // ==========
  // Scenarios
  initial begin
    i_sys_rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 10'h000; wd = 32'h0; be = 4'hf;
    pin_n = 6'h3f; run = 1'b0; slow = 1'b0; seed = 32'h00015436;
    cyc(16);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) if (i != 3 && i != 7) bus(1'b0, 8'hf4 + i, 32'h0);
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b0, 8'h10, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, 8'hf8, seed);
      bus(1'b1, 8'hf9, ~seed);
      bus(1'b0, 8'hf8, {24'h0, seed[7:0]});
      bus(1'b0, 8'hf9, {24'h0, ~seed[7:0]});
    end
    cmp(pa, {24'h0, seed[7:0]});
    cmp(pb, {24'h0, ~seed[7:0]});
    be <= 4'he;
    bus(1'b1, 8'hf8, 32'h0);
    be <= 4'hf;
    bus(1'b0, 8'hf8, {24'h0, seed[7:0]});
    bus(1'b1, 8'hf8, 32'h10);
    // Level mode, enables still off
    pin_n <= 6'h3e;
    cyc(8);
    cmp(req, 1'b0);
    pin_n <= 6'h3f;
    cyc(8);
    bus(1'b0, 8'hf6, 32'h01);
    bus(1'b1, 8'hf6, 32'h0);
    bus(1'b0, 8'hf6, 32'h0);
    pin_n <= 6'h3d;
    cyc(8);
    pin_n <= 6'h3f;
    cyc(8);
    bus(1'b1, 8'hf6, 32'h0);
    bus(1'b0, 8'hf6, 32'h02);
    bus(1'b1, 8'hf6, 32'h3f);
    bus(1'b0, 8'hf6, 32'h02);
    bus(1'b1, 8'hf6, 32'h0);
    bus(1'b0, 8'hf6, 32'h0);
    // Edge mode: held-low pin must not set the flag again
    bus(1'b1, 8'hf4, 32'h3f);
    pin_n <= 6'h3b;
    cyc(8);
    bus(1'b0, 8'hf6, 32'h04);
    cmp(flags, 32'h04);
    bus(1'b1, 8'hf6, 32'h0);
    bus(1'b0, 8'hf6, 32'h0);
    pin_n <= 6'h3f;
    bus(1'b1, 8'hfb, 32'h3f);
    bus(1'b1, 8'hfc, 32'h3f);
    bus(1'b1, 8'hf5, 32'h3f);
    pin_n <= 6'h27;
    cyc(8);
    cmp(req, 1'b1);
    cmp(cid, 3'h4);
    cmp(high, 1'b1);
    cmp(irq, 1'b1);
    run <= 1'b1;
    cyc(24);
    bus(1'b0, 8'hf6, 32'h0);
    cmp(req, 1'b0);
    bus(1'b0, 8'hfa, 32'h18);
    bus(1'b1, 8'hfb, 32'h08);
    bus(1'b0, 8'hfa, 32'h10);
    bus(1'b1, 8'hfc, 32'h0);
    cyc(1);
    cmp(irq, 1'b0);
    pin_n <= 6'h3f;
    // Pins settle high first, else level mode sets flags 3 and 4
    cyc(8);
    // Level mode: handling while pin low keeps the flag
    bus(1'b1, 8'hf4, 32'h0);
    slow <= 1'b1;
    pin_n <= 6'h1f;
    cyc(40);
    bus(1'b0, 8'hf6, 32'h20);
    pin_n <= 6'h3f;
    cyc(40);
    bus(1'b0, 8'hf6, 32'h0);
    run <= 1'b0;
    i_sys_rst <= 1'b1;
    cyc(2);
    i_sys_rst <= 1'b0;
    bus(1'b0, 8'hf8, 32'h0);
    bus(1'b0, 8'hf5, 32'h0);
    cmp(pb, 32'h0);
    cyc(2);
    complete_run;
  end
endmodule // external_irq_flag_priority_test
